// ==== lrc_ctrl_regs.sv ====
// control and status registers with two-wire management slave
`default_nettype none
module lrc_ctrl_regs
   import lrc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2c,
   parameter int RECAL_CYC = RECAL_CYCLES,
   parameter int ACT_TIMEOUT = ACT_TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // incoming link clock
   input wire logic incoming_clock_pair,
   // management port, open drain data
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // pins
   input wire logic powerdown_pin,
   input wire logic cm_above_thresh,
   output logic activity_out,
   // analog front end controls
   output logic link_out_en,
   output logic link_in_open,
   output logic clk_in_hiz,
   output logic data_in_hiz,
   output logic clk_hyst_en,
   output logic clk_hyst_20mv,
   output logic low_power_trim,
   output logic term_recal,
   output logic chip_reset_busy
);
   localparam int CAL_W = $clog2(RECAL_CYC + 1);

   logic [3:0] pin_s;
   logic scl_s, sda_s, pd_pin_s, cm_s;
   logic scl_p_q, sda_p_q;
   logic start_c, stop_c, rise_c, fall_c;
   lrc_state_e state_q;
   logic [3:0] cnt_q;
   logic [7:0] shreg_q, ptr_q, tx_q;
   logic low_q;
   logic wr_en;
   logic [7:0] chsel_q, inctl_q;
   logic [7:0] rst_cnt_q;
   logic chip_start, rst_done;
   logic [CAL_W-1:0] cal_cnt_q;
   logic det_active, pd, act_now;

   // bus lines pass inverted: a cleared synchroniser then reads idle-high
   lrc_sync #(.W(4)) u_sync (
      .clk(ref_clk),
      .rst(rst),
      .d({~scl_in, ~sda_in, powerdown_pin, cm_above_thresh}),
      .q(pin_s)
   );

   lrc_act_det #(.TIMEOUT(ACT_TIMEOUT)) u_act (
      .ref_clk(ref_clk),
      .rst(rst),
      .link_clk(incoming_clock_pair),
      .active(det_active)
   );

   assign scl_s = ~pin_s[3];
   assign sda_s = ~pin_s[2];
   assign pd_pin_s = pin_s[1];
   assign cm_s = pin_s[0];

   assign pd = chsel_q[CHSEL_PD_BIT] | pd_pin_s;
   // common-mode method is unreliable on small swings, kept selectable
   assign act_now = !pd &&
      (inctl_q[INCTL_ACT_MODE] ? cm_s : det_active);

   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_STATUS: v[STAT_ACT_BIT] = act_now;
         ADDR_CHSEL: v = chsel_q;
         ADDR_INCTL: v = inctl_q;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;
   assign rise_c = scl_s && !scl_p_q;
   assign fall_c = !scl_s && scl_p_q;

   // serial slave stays clocked in power-down: registers remain reachable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         shreg_q <= 8'h00;
         ptr_q <= 8'h00;
         tx_q <= 8'h00;
         low_q <= 1'b0;
      end else if (start_c) begin
         state_q <= ST_DEV;
         cnt_q <= 4'h0;
         low_q <= 1'b0;
      end else if (stop_c) begin
         state_q <= ST_IDLE;
         low_q <= 1'b0;
      end else if (state_q != ST_IDLE) begin
         if (rise_c) begin
            if (cnt_q != BITS_PER_BYTE) begin
               shreg_q <= {shreg_q[6:0], sda_s};
               cnt_q <= cnt_q + 4'h1;
            end else begin
               cnt_q <= 4'h0;
               if (state_q == ST_RD) begin
                  // own address ack still held: no data byte sent yet
                  if (sda_s) begin
                     state_q <= ST_IDLE;
                  end else if (!low_q) begin
                     ptr_q <= ptr_q + 8'h01;
                     tx_q <= rd_mux(ptr_q + 8'h01);
                  end
               end
            end
         end else if (fall_c) begin
            if (cnt_q == BITS_PER_BYTE) begin
               case (state_q)
                  ST_DEV: begin
                     if (shreg_q[7:1] == DEV_ADDR) begin
                        low_q <= 1'b1;
                        if (shreg_q[0]) begin
                           state_q <= ST_RD;
                           tx_q <= rd_mux(ptr_q);
                        end else begin
                           state_q <= ST_PTR;
                        end
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
                  ST_PTR: begin
                     ptr_q <= shreg_q;
                     low_q <= 1'b1;
                     state_q <= ST_WR;
                  end
                  ST_WR: begin
                     ptr_q <= ptr_q + 8'h01;
                     low_q <= 1'b1;
                  end
                  default: low_q <= 1'b0;
               endcase
            end else if (state_q == ST_RD) begin
               low_q <= ~tx_q[3'd7 - cnt_q[2:0]];
            end else begin
               low_q <= 1'b0;
            end
         end
      end
   end

   assign wr_en = fall_c && !start_c && !stop_c && state_q == ST_WR &&
      cnt_q == BITS_PER_BYTE;
   assign chip_start = wr_en && ptr_q == ADDR_CHSEL &&
      shreg_q[CHSEL_RST_BIT] && !chsel_q[CHSEL_RST_BIT];
   assign rst_done = rst_cnt_q == 8'h01;

   // writes during an internal reset are dropped; the reset owns the bank
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         chsel_q <= RST_CHSEL;
         inctl_q <= RST_INCTL;
      end else if (rst_done) begin
         chsel_q[CHSEL_RST_BIT] <= 1'b0;
      end else if (chsel_q[CHSEL_RST_BIT]) begin
         chsel_q <= chsel_q;
      end else if (chip_start) begin
         chsel_q <= RST_CHSEL | CHSEL_RST_MASK;
         inctl_q <= RST_INCTL;
      end else if (wr_en && ptr_q == ADDR_CHSEL) begin
         chsel_q <= shreg_q;
      end else if (wr_en && ptr_q == ADDR_INCTL) begin
         inctl_q <= shreg_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rst_cnt_q <= 8'h00;
      end else if (chip_start) begin
         rst_cnt_q <= CHIP_RST_CYCLES;
      end else if (rst_cnt_q != 8'h00) begin
         rst_cnt_q <= rst_cnt_q - 8'h01;
      end
   end

   // power-on calibration runs by itself; a chip reset repeats it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cal_cnt_q <= CAL_W'(RECAL_CYC);
      end else if (rst_done) begin
         cal_cnt_q <= CAL_W'(RECAL_CYC);
      end else if (cal_cnt_q != '0) begin
         cal_cnt_q <= cal_cnt_q - CAL_W'(1);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         activity_out <= 1'b0;
         link_out_en <= 1'b0;
         link_in_open <= 1'b0;
         clk_in_hiz <= 1'b0;
         data_in_hiz <= 1'b0;
         clk_hyst_en <= 1'b0;
         clk_hyst_20mv <= 1'b0;
         low_power_trim <= 1'b0;
         term_recal <= 1'b0;
         chip_reset_busy <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         sda_oe <= low_q;
         activity_out <= act_now;
         link_out_en <= !pd;
         link_in_open <= pd;
         clk_in_hiz <= inctl_q[INCTL_CLK_HIZ];
         data_in_hiz <= inctl_q[INCTL_DATA_HIZ];
         clk_hyst_en <= inctl_q[INCTL_HYST_EN];
         clk_hyst_20mv <= inctl_q[INCTL_HYST_MAG];
         low_power_trim <= inctl_q[INCTL_LOWPWR];
         // recalibrates as long as software holds the bit
         term_recal <= inctl_q[INCTL_RECAL] || cal_cnt_q != '0;
         chip_reset_busy <= chsel_q[CHSEL_RST_BIT];
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   localparam int RST_BOUND = 20;

   a_pd_or_pin: assert property (
      (pd_pin_s || chsel_q[CHSEL_PD_BIT]) |=> !link_out_en && link_in_open)
      else $error("power-down source did not disable link");

   a_pd_release: assert property (
      (!pd_pin_s && !chsel_q[CHSEL_PD_BIT]) |=> link_out_en)
      else $error("link outputs stayed off without power-down");

   a_status_bit: assert property (
      (fall_c && state_q == ST_DEV && cnt_q == BITS_PER_BYTE &&
       shreg_q == {DEV_ADDR, 1'b1} && ptr_q == ADDR_STATUS && !start_c &&
       !stop_c) |=> tx_q[STAT_ACT_BIT] == $past(act_now))
      else $error("status read does not show activity");

   a_rst_selfclr: assert property (
      $rose(chsel_q[CHSEL_RST_BIT]) |-> ##[1:RST_BOUND]
      !chsel_q[CHSEL_RST_BIT])
      else $error("chip reset bit did not clear itself");

   a_rst_default: assert property (
      chip_start |=> chsel_q == (RST_CHSEL | CHSEL_RST_MASK) &&
      inctl_q == RST_INCTL)
      else $error("chip reset did not restore defaults");

   a_inctl_wback: assert property (
      (wr_en && ptr_q == ADDR_INCTL && !chsel_q[CHSEL_RST_BIT] &&
       !rst_done) |=> ##1 clk_in_hiz == $past(shreg_q[INCTL_CLK_HIZ], 2) &&
      data_in_hiz == $past(shreg_q[INCTL_DATA_HIZ], 2))
      else $error("input control write not applied");

   a_recal_hold: assert property (
      inctl_q[INCTL_RECAL] [*2] |=> term_recal)
      else $error("recalibrate not driven while bit high");

   a_poweron_cal: assert property (
      (cal_cnt_q != '0) |=> term_recal)
      else $error("automatic calibration not driven");

   a_cm_mode: assert property (
      (inctl_q[INCTL_ACT_MODE] && !pd && cm_s) |=> activity_out)
      else $error("common-mode activity not reported");

   a_act_pd: assert property (
      pd |=> !activity_out)
      else $error("activity reported in power-down");

   a_ack_in_pd: assert property (
      (pd && fall_c && state_q == ST_PTR && cnt_q == BITS_PER_BYTE &&
       !start_c && !stop_c) |=> ##1 sda_oe)
      else $error("no acknowledge during power-down");

   a_hyst_wback: assert property (
      (wr_en && ptr_q == ADDR_INCTL && !chsel_q[CHSEL_RST_BIT] &&
       !rst_done) |=> ##1
      clk_hyst_en == $past(shreg_q[INCTL_HYST_EN], 2) &&
      clk_hyst_20mv == $past(shreg_q[INCTL_HYST_MAG], 2))
      else $error("hysteresis controls not applied");

   a_recal_wback: assert property (
      (wr_en && ptr_q == ADDR_INCTL && shreg_q[INCTL_RECAL] &&
       !chsel_q[CHSEL_RST_BIT] && !rst_done) |=> ##1 term_recal)
      else $error("recalibrate bit not driven");

   a_rst_len: assert property (
      $rose(chsel_q[CHSEL_RST_BIT]) |-> ##15 chsel_q[CHSEL_RST_BIT]
      ##1 !chsel_q[CHSEL_RST_BIT])
      else $error("chip reset did not last its cycle count");

   a_busy_out: assert property (
      $rose(chsel_q[CHSEL_RST_BIT]) |=> chip_reset_busy)
      else $error("chip reset not shown as busy");

   a_chsel_wr: assert property (
      (wr_en && ptr_q == ADDR_CHSEL && !chsel_q[CHSEL_RST_BIT] &&
       !rst_done && !shreg_q[CHSEL_RST_BIT]) |=> chsel_q == $past(shreg_q))
      else $error("select write not stored");

   a_inctl_wr: assert property (
      (wr_en && ptr_q == ADDR_INCTL && !chsel_q[CHSEL_RST_BIT] &&
       !rst_done) |=> inctl_q == $past(shreg_q))
      else $error("input control write not stored");

   a_rd_ptr_hold: assert property (
      (rise_c && state_q == ST_RD && cnt_q == BITS_PER_BYTE && low_q &&
       !start_c && !stop_c) |=> $stable(ptr_q))
      else $error("pointer moved on own address acknowledge");

   a_act_toggle: assert property (
      (!pd && !inctl_q[INCTL_ACT_MODE] && det_active) |=> activity_out)
      else $error("link clock activity not reported");

   a_act_level: assert property (
      (inctl_q[INCTL_ACT_MODE] && !cm_s) |=> !activity_out)
      else $error("toggles reported in common-mode method");

   a_recal_restart: assert property (
      rst_done |=> cal_cnt_q == CAL_W'(RECAL_CYC))
      else $error("calibration not restarted after chip reset");
endmodule
`default_nettype wire

// ==== lrc_pkg.sv ====
// constants and types for the link regenerator control registers
// Notes on behaviour
// - status bit 2 shows link clock activity (input bit 4 low) or common-mode level (bit 4 set), 0 in power-down
// - select bit 4 starts self-clearing chip reset
// - select bit 5 forces minimum-power mode
// - power-down is register bit OR pin
// - management port keeps working in power-down
// - input bit 2 floats clock inputs
// - input bit 3 floats data inputs
// - input bit 4 picks activity detect method
// - input bit 5 enables clock-input hysteresis
// - input bit 6 picks 10 or 20 mV
// - input bit 7 high recalibrates termination
// - termination calibrates automatically after power-on
// - activity pin follows link clock activity (input bit 4 low) or common-mode level (bit 4 set), low in power-down
`default_nettype none
package lrc_pkg;
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_CHSEL = 8'h02;
   localparam logic [7:0] ADDR_INCTL = 8'h03;
   localparam logic [7:0] RST_CHSEL = 8'h0c;
   localparam logic [7:0] RST_INCTL = 8'h12;
   localparam logic [7:0] CHSEL_RST_MASK = 8'h10;
   localparam int STAT_ACT_BIT = 2;
   localparam int CHSEL_RST_BIT = 4;
   localparam int CHSEL_PD_BIT = 5;
   localparam int INCTL_LOWPWR = 0;
   localparam int INCTL_CLK_HIZ = 2;
   localparam int INCTL_DATA_HIZ = 3;
   localparam int INCTL_ACT_MODE = 4;
   localparam int INCTL_HYST_EN = 5;
   localparam int INCTL_HYST_MAG = 6;
   localparam int INCTL_RECAL = 7;
   localparam int REF_CLK_MHZ = 200;
   localparam int RECAL_MIN_NS = 1000000;
   localparam int RECAL_CYCLES = (RECAL_MIN_NS * REF_CLK_MHZ + 999) / 1000;
   localparam logic [7:0] CHIP_RST_CYCLES = 8'h10;
   localparam int ACT_TIMEOUT_CYCLES = 64;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_DEV = 5'b00010,
      ST_PTR = 5'b00100,
      ST_WR = 5'b01000,
      ST_RD = 5'b10000
   } lrc_state_e;
endpackage
`default_nettype wire

// ==== lrc_sync.sv ====
// two-flop synchroniser for asynchronous inputs
`default_nettype none
module lrc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== lrc_act_det.sv ====
// link clock activity detector, toggle crossing into the reference domain
`default_nettype none
module lrc_act_det #(
   parameter int TIMEOUT = 64
) (
   // reference domain
   input wire logic ref_clk,
   input wire logic rst,
   // link domain
   input wire logic link_clk,
   // result
   output logic active
);
   localparam int CW = $clog2(TIMEOUT + 1);
   logic tog_q;
   logic s1_q, s2_q, s3_q;
   logic [CW-1:0] cnt_q;

   // link clock may stop: only a toggle crosses, so nothing waits on it
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         tog_q <= 1'b0;
      end else begin
         tog_q <= ~tog_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= tog_q;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // retriggerable window: active until TIMEOUT cycles pass with no toggle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         active <= 1'b0;
      end else if (s2_q ^ s3_q) begin
         cnt_q <= CW'(TIMEOUT);
         active <= 1'b1;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - CW'(1);
         active <= (cnt_q != CW'(1));
      end else begin
         active <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== lrc_host.sv ====
// two-wire management host model for the control register block
`default_nettype none
module lrc_host
   import lrc_pkg::*;
#(
   parameter logic [6:0] DEV = 7'h2c,
   parameter int HALF = 5
) (
   // clock
   input wire logic clk,
   // management wire
   input wire logic sda,
   output logic scl,
   output logic pull
);
   timeunit 1ns;
   timeprecision 100ps;
   int nacks = 0;
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic hp();
      repeat (HALF) @(posedge clk);
      #1;
   endtask
   // data moves mid low phase, well clear of either clock edge
   task automatic bit_io(input logic b, output logic r);
      hp();
      pull = ~b;
      hp();
      scl = 1'b1;
      hp();
      hp();
      r = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      hp();
      pull = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      pull = 1'b1;
      hp();
      scl = 1'b0;
   endtask
   task automatic stop();
      hp();
      pull = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      pull = 1'b0;
      hp();
   endtask
   task automatic send8(input logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(v[i], r);
      end
      bit_io(1'b1, r);
      if (r !== 1'b0) begin
         nacks++;
      end
   endtask
   task automatic recv8(output logic [7:0] v);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bit_io(1'b1, r);
         v = {v[6:0], r};
      end
      bit_io(1'b1, r);
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
      start();
      send8({DEV, 1'b0});
      send8(ptr);
      send8((ptr == ADDR_CHSEL) ? {v[7:4], 4'hc} : v);
      stop();
   endtask
   task automatic rd(input logic [7:0] ptr, output logic [7:0] v);
      start();
      send8({DEV, 1'b0});
      send8(ptr);
      start();
      send8({DEV, 1'b1});
      recv8(v);
      stop();
   endtask
   task automatic probe(input logic [6:0] a);
      start();
      send8({a, 1'b0});
      stop();
   endtask
   task automatic setup();
      wr(ADDR_INCTL, 8'h63);
   endtask
   // hold is in reference cycles, scaled down for simulation
   task automatic recal(input int hold);
      wr(ADDR_INCTL, 8'he3);
      repeat (hold) @(posedge clk);
      #1;
      wr(ADDR_INCTL, 8'h63);
   endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the link regenerator control registers
`default_nettype none
module tb_top
   import lrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int RECAL = 20;
   localparam int ACT_TO = 16;
   localparam logic [6:0] DEV = 7'h2c;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic link_clk = 1'b0;
   logic link_on = 1'b0;
   logic powerdown_pin = 1'b0;
   logic cm_above_thresh = 1'b0;
   logic scl, host_pull, sda_out, sda_oe, activity_out, link_out_en;
   logic link_in_open, clk_in_hiz, data_in_hiz, clk_hyst_en;
   logic clk_hyst_20mv, low_power_trim, term_recal, chip_reset_busy;
   wire sda;
   int n_errors = 0;
   int samples_checked = 0;
   int busy_cyc = 0;
   int n0;
   logic [7:0] v, got;
   logic [7:0] corner [3] = '{8'h00, 8'hff, 8'h63};
   // pull-up wins unless either side drives the line
   assign sda = ~host_pull & (sda_oe ? sda_out : 1'b1);
   always #2.5 ref_clk = ~ref_clk;
   // link clock stands still while no frame is sent
   initial begin
      #3.7;
      forever #6 link_clk = link_on ? ~link_clk : 1'b0;
   end
   always @(posedge ref_clk) begin
      if (chip_reset_busy === 1'b1) begin
         busy_cyc <= busy_cyc + 1;
      end
   end
   lrc_ctrl_regs #(.DEV_ADDR(DEV), .RECAL_CYC(RECAL), .ACT_TIMEOUT(ACT_TO))
   dut_u (.ref_clk(ref_clk), .rst(rst), .incoming_clock_pair(link_clk),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .powerdown_pin(powerdown_pin), .cm_above_thresh(cm_above_thresh),
      .activity_out(activity_out), .link_out_en(link_out_en),
      .link_in_open(link_in_open), .clk_in_hiz(clk_in_hiz),
      .data_in_hiz(data_in_hiz), .clk_hyst_en(clk_hyst_en),
      .clk_hyst_20mv(clk_hyst_20mv), .low_power_trim(low_power_trim),
      .term_recal(term_recal), .chip_reset_busy(chip_reset_busy));
   lrc_host #(.DEV(DEV)) host_u (.clk(ref_clk), .sda(sda), .scl(scl),
      .pull(host_pull));
   function automatic logic [7:0] front(input logic [7:0] c);
      return {2'b00, c[7], c[6], c[5], c[3], c[2], c[0]};
   endfunction
   function automatic logic [7:0] stat(input logic a);
      return {5'h00, a, 2'b00};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
      input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what,
            seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge ref_clk);
      n_errors++;
      $display("unexpected at %0t: run timed out", $time);
      end_of_test();
   end
   initial begin
      void'($urandom(32'h82b587ee));
      cyc(2);
      rst = 1'b0;
      cyc(2);
      chk(term_recal, 8'h01, "power-on calibration");
      cyc(RECAL + 4);
      chk({term_recal, clk_hyst_20mv, clk_hyst_en, data_in_hiz, clk_in_hiz,
         low_power_trim}, front(RST_INCTL), "reset outputs");
      host_u.rd(ADDR_CHSEL, got);
      chk(got, RST_CHSEL, "select reset");
      host_u.rd(ADDR_INCTL, got);
      chk(got, RST_INCTL, "input reset");
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         v = (i < 3) ? corner[i] : 8'($urandom);
         host_u.wr(ADDR_INCTL, v);
         cyc(2);
         chk({term_recal, clk_hyst_20mv, clk_hyst_en, data_in_hiz,
            clk_in_hiz, low_power_trim}, front(v), "front end");
         host_u.rd(ADDR_INCTL, got);
         chk(got, v, "input readback");
      end
      host_u.setup();
      $display("test input control done");
      link_on = 1'b1;
      cyc(20);
      chk(activity_out, 8'h01, "toggle activity");
      host_u.rd(ADDR_STATUS, got);
      chk(got, stat(1'b1), "status active");
      link_on = 1'b0;
      cyc(ACT_TO + 10);
      chk(activity_out, 8'h00, "activity lost");
      host_u.rd(ADDR_STATUS, got);
      chk(got, stat(1'b0), "status idle");
      host_u.wr(ADDR_INCTL, 8'h73);
      cm_above_thresh = 1'b1;
      cyc(8);
      chk(activity_out, 8'h01, "level activity");
      cm_above_thresh = 1'b0;
      link_on = 1'b1;
      cyc(20);
      chk(activity_out, 8'h00, "toggles ignored");
      host_u.setup();
      $display("test activity done");
      host_u.wr(ADDR_CHSEL, 8'h20);
      cyc(2);
      chk({link_out_en, link_in_open, activity_out}, 8'h02, "reg pd");
      host_u.rd(ADDR_CHSEL, got);
      chk(got, 8'h2c, "select in pd");
      host_u.wr(ADDR_CHSEL, 8'h0c);
      powerdown_pin = 1'b1;
      cyc(4);
      chk({link_out_en, link_in_open, activity_out}, 8'h02, "pin pd");
      host_u.rd(ADDR_INCTL, got);
      chk(got, 8'h63, "access in pd");
      powerdown_pin = 1'b0;
      cyc(20);
      chk({link_out_en, link_in_open, activity_out}, 8'h05, "pd exit");
      host_u.recal(RECAL);
      chk(term_recal, 8'h00, "recal over");
      $display("test power-down done");
      busy_cyc = 0;
      host_u.wr(ADDR_CHSEL, 8'h10);
      cyc(4);
      chk(8'(busy_cyc), CHIP_RST_CYCLES, "reset length");
      host_u.rd(ADDR_CHSEL, got);
      chk(got, RST_CHSEL, "reset bit clears");
      host_u.rd(ADDR_INCTL, got);
      chk(got, RST_INCTL, "input restored");
      host_u.wr(ADDR_STATUS, 8'hff);
      host_u.rd(ADDR_STATUS, got);
      chk(got, stat(1'b0), "status read only");
      n0 = host_u.nacks;
      host_u.probe(DEV ^ 7'h01);
      chk(8'(host_u.nacks - n0), 8'h01, "foreign address");
      $display("test chip reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
